/* File: pkg/hcs_pkg.sv */
// Constants and types for the host-side command, status and data registers
package hcs_pkg;

  // ------------------------------------------------------------------
  // Host addresses
  // ------------------------------------------------------------------
  localparam logic [2:0] HCS_ADDR_CTRL   = 3'h0;
  localparam logic [2:0] HCS_ADDR_CMD    = 3'h1;
  localparam logic [2:0] HCS_ADDR_STAT   = 3'h2;
  localparam logic [2:0] HCS_ADDR_IVEC   = 3'h3;
  localparam logic [2:0] HCS_ADDR_DATA_A = 3'h6;
  localparam logic [2:0] HCS_ADDR_DATA_B = 3'h7;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int         HCS_CMD_FLAG_BIT = 7;
  localparam int         HCS_ST_RF_BIT    = 0;
  localparam int         HCS_ST_TE_BIT    = 1;
  localparam int         HCS_ST_TC_BIT    = 2;
  localparam int         HCS_ST_F2_BIT    = 3;
  localparam int         HCS_ST_F3_BIT    = 4;
  localparam int         HCS_ST_REQ_BIT   = 7;
  localparam logic [6:0] HCS_CMD_IDX_RST  = 7'h32;
  localparam logic [7:0] HCS_IVEC_RST     = 8'h0f;
  localparam logic [7:0] HCS_BYTE_ZERO    = 8'h00;

  // ------------------------------------------------------------------
  // Data path sizes
  // ------------------------------------------------------------------
  localparam int HCS_WORD_W     = 16;
  localparam int HCS_FIFO_DEPTH = 8;

  // Host pin bundle as seen through the synchroniser
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic       ack;
    logic [2:0] addr;
    logic [7:0] data;
  } hcs_pins_t;

endpackage

/* File: src/hcs_top.sv */
// Host-side command, status and data registers with core-side word path
//
// What this block does
// - Seven-bit index picks one of 128 routines; address is twice it.
// - Index loads 0x32 on hardware, software, individual and stop resets.
// - Host writing one to bit 7 requests core; core acknowledge clears it.
// - Request flag also shows as command pending to the core.
// - Status register is read-only; host writes there change nothing.
// - Receive-full sets on word arrival, clears on host read at address 7.
// - Transmit-empty sets on move to core, clears on host write at 7.
// - Transfer-clear set only while transmit bytes and core word are empty.
// - Status bits 3 and 4 mirror two core-owned flags.
// - Status bits 5 and 6 read as zero.
// - Status bit 7 shows request pin, or either split request pin.
// - Request asserts on enabled receive-full or enabled transmit-empty.
// - Interrupt vector drives data bus while request and acknowledge held, except in split mode.
// - Interrupt vector resets to default on hardware and software reset.
// - Receive bytes return core word halves; read at address 7 clears full.
// - Byte order select swaps high and low bytes between addresses 6 and 7.
// - Write at address 7 clears transmit-empty; bytes feed core halves.
// - Both flags clear moves bytes as one word, setting both flags.
// - Each request enable gates its own flag onto the request.
// - Split mode: request pin transmit-only, acknowledge pin receive-only.
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Word FIFO between core transmit word and receive bytes
// ----------------------------------------------------------------------
module hcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } hcs_fifo_st_t;

  hcs_fifo_st_t st_r;
  hcs_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data  = st_r.mem[st_r.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wptr] = in_data;
      st_nxt.wptr = (st_r.wptr == AW'(DEPTH-1)) ? '0 : st_r.wptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rptr = (st_r.rptr == AW'(DEPTH-1)) ? '0 : st_r.rptr + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      st_nxt.wptr  = '0;
      st_nxt.rptr  = '0;
      st_nxt.count = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ----------------------------------------------------------------------
// Register block top
// ----------------------------------------------------------------------
module hcs_top
  import hcs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  soft_rst,
  input  wire logic                  indiv_rst,
  input  wire logic                  stop_rst,
  input  wire logic                  host_cs_n,
  input  wire logic                  host_rd_n,
  input  wire logic                  host_wr_n,
  input  wire logic [2:0]            host_addr,
  input  wire logic [7:0]            host_data_in,
  output logic      [7:0]            host_data_out,
  output logic                       host_data_oe,
  output logic                       host_request_pin,
  input  wire logic                  ack_pin_in,
  output logic                       ack_pin_out,
  output logic                       ack_pin_oe,
  input  wire logic                  receive_request_enable,
  input  wire logic                  transmit_request_enable,
  input  wire logic                  split_request_mode,
  input  wire logic                  byte_order_select,
  input  wire logic                  core_flag_two,
  input  wire logic                  core_flag_three,
  output logic                       core_cmd_request,
  output logic      [7:0]            core_cmd_vector_addr,
  output logic                       command_pending,
  input  wire logic                  core_cmd_ack,
  input  wire logic [HCS_WORD_W-1:0] core_transmit_word,
  input  wire logic                  core_tx_valid,
  output logic                       core_tx_ready,
  output logic      [HCS_WORD_W-1:0] core_receive_word,
  output logic                       core_receive_full,
  input  wire logic                  core_rx_take,
  output logic                       transfer_clear
);

  typedef struct packed {
    hcs_pins_t                 s1;
    hcs_pins_t                 s2;
    logic                      rd_prev;
    logic                      wr_prev;
    logic [2:0]                rd_addr;
    logic [6:0]                cmd_idx;
    logic                      cmd_flag;
    logic [7:0]                ivec;
    logic [HCS_WORD_W-1:0]     rx_word;
    logic                      rf;
    logic [7:0]                tx_hi;
    logic [7:0]                tx_lo;
    logic                      te;
    logic [HCS_WORD_W-1:0]     crx_word;
    logic                      crf;
    logic [7:0]                dout;
    logic                      doe;
  } hcs_st_t;

  localparam hcs_st_t HCS_ST_RST = '{
    cmd_idx: HCS_CMD_IDX_RST,
    ivec:    HCS_IVEC_RST,
    te:      1'b1,
    default: '0
  };

  hcs_st_t               st_r;
  hcs_st_t               st_nxt;
  hcs_pins_t             pins;
  logic [HCS_WORD_W-1:0] fifo_data;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic                  any_rst;
  logic                  rx_req;
  logic                  tx_req;
  logic                  req_any;
  logic                  rd_act;
  logic                  wr_act;
  logic                  vec_drive;
  logic                  hi_at_a;
  logic [7:0]            status_byte;
  logic [7:0]            rd_byte;
  logic [7:0]            rx_hi;
  logic [7:0]            rx_lo;

  // ------------------------------------------------------------------
  // Core transmit word buffer
  // ------------------------------------------------------------------
  assign any_rst  = soft_rst | indiv_rst | stop_rst;
  assign fifo_pop = ~st_r.rf;

  hcs_fifo #(
    .WIDTH (HCS_WORD_W),
    .DEPTH (HCS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (any_rst),
    .in_data   (core_transmit_word),
    .in_valid  (core_tx_valid),
    .in_ready  (core_tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ------------------------------------------------------------------
  // Request pins and status
  // ------------------------------------------------------------------
  assign pins.cs   = ~host_cs_n;
  assign pins.rd   = ~host_rd_n;
  assign pins.wr   = ~host_wr_n;
  assign pins.ack  = ack_pin_in;
  assign pins.addr = host_addr;
  assign pins.data = host_data_in;

  assign rx_req  = st_r.rf & receive_request_enable;
  assign tx_req  = st_r.te & transmit_request_enable;
  assign req_any = rx_req | tx_req;

  assign host_request_pin = split_request_mode ? tx_req : req_any;
  assign ack_pin_out      = split_request_mode & rx_req;
  assign ack_pin_oe       = split_request_mode;

  assign transfer_clear = st_r.te & ~st_r.crf;

  always_comb begin
    status_byte                 = HCS_BYTE_ZERO;
    status_byte[HCS_ST_RF_BIT]  = st_r.rf;
    status_byte[HCS_ST_TE_BIT]  = st_r.te;
    status_byte[HCS_ST_TC_BIT]  = transfer_clear;
    status_byte[HCS_ST_F2_BIT]  = core_flag_two;
    status_byte[HCS_ST_F3_BIT]  = core_flag_three;
    status_byte[HCS_ST_REQ_BIT] = req_any;
  end

  // ------------------------------------------------------------------
  // Host read multiplexer
  // ------------------------------------------------------------------
  assign hi_at_a = ~byte_order_select;
  assign {rx_hi, rx_lo} = st_r.rx_word;

  always_comb begin
    rd_byte = HCS_BYTE_ZERO;
    case (st_r.s2.addr)
      HCS_ADDR_CMD: begin
        rd_byte = {st_r.cmd_flag, st_r.cmd_idx};
      end
      HCS_ADDR_STAT: begin
        rd_byte = status_byte;
      end
      HCS_ADDR_IVEC: begin
        rd_byte = st_r.ivec;
      end
      HCS_ADDR_DATA_A: begin
        rd_byte = hi_at_a ? rx_hi : rx_lo;
      end
      HCS_ADDR_DATA_B: begin
        rd_byte = hi_at_a ? rx_lo : rx_hi;
      end
      default: begin
        rd_byte = HCS_BYTE_ZERO;
      end
    endcase
  end

  assign rd_act    = st_r.s2.cs & st_r.s2.rd;
  assign wr_act    = st_r.s2.cs & st_r.s2.wr;
  assign vec_drive = ~split_request_mode & req_any & st_r.s2.ack;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.s1      = pins;
    st_nxt.s2      = st_r.s1;
    st_nxt.rd_prev = rd_act;
    st_nxt.wr_prev = wr_act;

    // Read start latches data; end of read applies side effect
    if (rd_act & ~st_r.rd_prev) begin
      st_nxt.rd_addr = st_r.s2.addr;
      st_nxt.dout    = rd_byte;
    end
    if (~rd_act & st_r.rd_prev & (st_r.rd_addr == HCS_ADDR_DATA_B)) begin
      st_nxt.rf = 1'b0;
    end
    st_nxt.doe = (rd_act & (st_r.s2.addr != HCS_ADDR_CTRL)) | vec_drive;
    if (vec_drive) begin
      st_nxt.dout = st_r.ivec;
    end

    // Host set below wins over a same-cycle acknowledge
    if (core_cmd_ack) begin
      st_nxt.cmd_flag = 1'b0;
    end

    if (wr_act & ~st_r.wr_prev) begin
      case (st_r.s2.addr)
        HCS_ADDR_CMD: begin
          st_nxt.cmd_idx = st_r.s2.data[HCS_CMD_FLAG_BIT-1:0];
          if (st_r.s2.data[HCS_CMD_FLAG_BIT]) begin
            st_nxt.cmd_flag = 1'b1;
          end
        end
        HCS_ADDR_IVEC: begin
          st_nxt.ivec = st_r.s2.data;
        end
        HCS_ADDR_DATA_A: begin
          if (hi_at_a) begin
            st_nxt.tx_hi = st_r.s2.data;
          end else begin
            st_nxt.tx_lo = st_r.s2.data;
          end
        end
        HCS_ADDR_DATA_B: begin
          if (hi_at_a) begin
            st_nxt.tx_lo = st_r.s2.data;
          end else begin
            st_nxt.tx_hi = st_r.s2.data;
          end
          st_nxt.te = 1'b0;
        end
        default: begin
          // Control, status and unused addresses ignore writes
          st_nxt.rd_addr = st_nxt.rd_addr;
        end
      endcase
    end

    // Core word into receive bytes
    if (fifo_valid & ~st_r.rf) begin
      st_nxt.rx_word = fifo_data;
      st_nxt.rf      = 1'b1;
    end

    // Transmit bytes into core receive word
    if (core_rx_take) begin
      st_nxt.crf = 1'b0;
    end
    if (~st_r.te & ~st_r.crf) begin
      st_nxt.crx_word = {st_r.tx_hi, st_r.tx_lo};
      st_nxt.te       = 1'b1;
      st_nxt.crf      = 1'b1;
    end

    if (any_rst) begin
      st_nxt.cmd_idx  = HCS_CMD_IDX_RST;
      st_nxt.cmd_flag = 1'b0;
      st_nxt.rf       = 1'b0;
      st_nxt.te       = 1'b1;
      st_nxt.crf      = 1'b0;
    end
    if (soft_rst) begin
      st_nxt.ivec = HCS_IVEC_RST;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= HCS_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign host_data_out        = st_r.dout;
  assign host_data_oe         = st_r.doe;
  assign core_cmd_request     = st_r.cmd_flag;
  assign command_pending      = st_r.cmd_flag;
  assign core_cmd_vector_addr = {st_r.cmd_idx, 1'b0};
  assign core_receive_word    = st_r.crx_word;
  assign core_receive_full    = st_r.crf;

endmodule

/* File: verif/hcs_chk_sva.sv */
// Port-level assertions for the host-side register block
`timescale 1ns/10ps
module hcs_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       soft_rst,
  input wire logic       indiv_rst,
  input wire logic       stop_rst,
  input wire logic       receive_request_enable,
  input wire logic       transmit_request_enable,
  input wire logic       split_request_mode,
  input wire logic       host_request_pin,
  input wire logic       ack_pin_out,
  input wire logic       ack_pin_oe,
  input wire logic       core_cmd_request,
  input wire logic [7:0] core_cmd_vector_addr,
  input wire logic       command_pending,
  input wire logic       core_cmd_ack,
  input wire logic       core_receive_full,
  input wire logic       core_rx_take,
  input wire logic       transfer_clear
);
  logic any_rst;
  assign any_rst = soft_rst | indiv_rst | stop_rst;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ------------------------
  // Command path
  // ------------------------
  chk_vec_hold: assert property (
    core_cmd_request && !any_rst |=> $stable(core_cmd_vector_addr)
      && !core_cmd_vector_addr[0]) else $error("vector moved");
  chk_rst_index: assert property (
    any_rst |=> core_cmd_vector_addr == 8'h64 && !core_cmd_request)
    else $error("index reset");
  chk_pend_mirror: assert property (
    command_pending == core_cmd_request) else $error("pending");
  chk_ack_clear: assert property (
    $fell(core_cmd_request) |-> $past(core_cmd_ack) || $past(any_rst))
    else $error("flag fell");
  // ------------------------
  // Word path and pins
  // ------------------------
  chk_tc_gate: assert property (
    core_receive_full |-> !transfer_clear) else $error("transfer clear");
  chk_rst_empty: assert property (
    any_rst |=> transfer_clear && !core_receive_full)
    else $error("reset empty");
  chk_crf_hold: assert property (
    core_receive_full && !core_rx_take && !any_rst |=> core_receive_full)
    else $error("word lost");
  chk_split_pins: assert property (
    ack_pin_oe == split_request_mode
      && (split_request_mode || !ack_pin_out)) else $error("split pins");
  chk_req_gate: assert property (
    !transmit_request_enable && (split_request_mode
      || !receive_request_enable) |-> !host_request_pin)
    else $error("request gate");
  chk_ack_gate: assert property (
    split_request_mode && !receive_request_enable |-> !ack_pin_out)
    else $error("receive request");
  chk_req_assert: assert property (
    transmit_request_enable && transfer_clear |-> host_request_pin)
    else $error("request missing");
  cov_cmd: cover property ($fell(core_cmd_request));
  cov_word: cover property ($rose(core_receive_full));
  cov_split: cover property (split_request_mode && ack_pin_out);
endmodule

/* File: verif/hcs_host_model.sv */
// Host processor bus model driving the register block pins
`timescale 1ns/10ps
module hcs_host_model (
  input  wire logic       clk,
  output logic            host_cs_n,
  output logic            host_rd_n,
  output logic            host_wr_n,
  output logic [2:0]      host_addr,
  output logic [7:0]      host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  output logic            ack_pin_in,
  input  wire logic       ack_pin_out,
  input  wire logic       ack_pin_oe
);
  logic [7:0] drv = 8'h00;
  logic       drv_en = 1'b0;
  logic       ack_drv = 1'b0;
  initial begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 3'h0;
  end
  // Released bus shows the inverse of the last value
  always_comb begin
    host_data_in = host_data_oe ? host_data_out : drv_en ? drv : ~drv;
    ack_pin_in = ack_pin_oe ? ack_pin_out : ack_drv;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Control address never written
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    host_addr = a;
    drv = v;
    drv_en = 1'b1;
    host_cs_n = 1'b0;
    host_wr_n = 1'b0;
    cyc(6);
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    cyc(4);
    drv_en = 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    host_addr = a;
    host_cs_n = 1'b0;
    host_rd_n = 1'b0;
    cyc(6);
    v = host_data_in;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    cyc(6);
  endtask
endmodule

/* File: verif/test_hcs_top.sv */
// Self-checking bench for the host-side register block
`timescale 1ns/10ps
module test_hcs_top;
  import hcs_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        soft_rst, indiv_rst, stop_rst, core_cmd_ack;
  logic        receive_request_enable, transmit_request_enable;
  logic        split_request_mode, byte_order_select;
  logic        core_flag_two, core_flag_three, core_tx_valid, core_rx_take;
  logic        host_cs_n, host_rd_n, host_wr_n, host_data_oe, ack_pin_in;
  logic        host_request_pin, ack_pin_out, ack_pin_oe, core_tx_ready;
  logic        core_cmd_request, command_pending;
  logic        core_receive_full, transfer_clear;
  logic [2:0]  host_addr;
  logic [7:0]  host_data_in, host_data_out, core_cmd_vector_addr, d, v;
  logic [15:0] core_transmit_word, core_receive_word;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          k;

  hcs_top hcs_top_inst (.clk, .nrst, .soft_rst, .indiv_rst, .stop_rst,
    .host_cs_n, .host_rd_n, .host_wr_n, .host_addr, .host_data_in,
    .host_data_out, .host_data_oe, .host_request_pin, .ack_pin_in,
    .ack_pin_out, .ack_pin_oe, .receive_request_enable,
    .transmit_request_enable, .split_request_mode, .byte_order_select,
    .core_flag_two, .core_flag_three, .core_cmd_request,
    .core_cmd_vector_addr, .command_pending, .core_cmd_ack,
    .core_transmit_word, .core_tx_valid, .core_tx_ready,
    .core_receive_word, .core_receive_full, .core_rx_take, .transfer_clear);
  hcs_host_model hcs_host_model_inst (.clk, .host_cs_n, .host_rd_n,
    .host_wr_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
    .ack_pin_in, .ack_pin_out, .ack_pin_oe);

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  // --------------------
  // Access and compare
  // --------------------
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
    hcs_host_model_inst.rd(a, d);
    chk(n, 24'(e), 24'(d));
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] x);
    hcs_host_model_inst.wr(a, x);
  endtask
  task automatic st(input int n);
    hcs_host_model_inst.cyc(n);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // --------------------
  // Test sequence
  // --------------------
  initial begin
    {soft_rst, indiv_rst, stop_rst, core_cmd_ack, core_flag_three} = '0;
    {receive_request_enable, transmit_request_enable} = '0;
    {split_request_mode, byte_order_select, core_tx_valid} = '0;
    core_rx_take = 1'b0;
    core_flag_two = 1'b1;
    core_transmit_word = 16'h0000;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    st(2);
    rc(HCS_ADDR_CMD, 8'h32, "cmd");
    rc(HCS_ADDR_IVEC, 8'h0f, "ivec");
    w(HCS_ADDR_STAT, 8'hff);
    rc(HCS_ADDR_STAT, 8'h0e, "stat");
    rc(3'h4, 8'h00, "unused");
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'hff : 8'h85;
      w(HCS_ADDR_CMD, v);
      chk("cvec", 24'({v[6:0], 1'b0}), 24'(core_cmd_vector_addr));
      chk("pend", 24'h3, 24'({core_cmd_request, command_pending}));
      rc(HCS_ADDR_CMD, v, "cmd");
      core_cmd_ack = 1'b1;
      st(1);
      core_cmd_ack = 1'b0;
      st(1);
      rc(HCS_ADDR_CMD, {1'b0, v[6:0]}, "cmd");
    end
    for (int r = 0; r < 3; r++) begin
      w(HCS_ADDR_IVEC, 8'h5a);
      w(HCS_ADDR_CMD, 8'h11);
      {soft_rst, indiv_rst, stop_rst} = 3'b100 >> r;
      st(1);
      {soft_rst, indiv_rst, stop_rst} = 3'b000;
      rc(HCS_ADDR_CMD, 8'h32, "cmd");
      rc(HCS_ADDR_IVEC, r ? 8'h5a : 8'h0f, "ivec");
    end
    {core_flag_two, core_flag_three} = 2'b01;
    w(HCS_ADDR_DATA_A, 8'ha1);
    w(HCS_ADDR_DATA_B, 8'hb2);
    chk("rxw", 24'h1a1b2,
        24'({core_receive_full, core_receive_word}));
    rc(HCS_ADDR_STAT, 8'h12, "stat");
    byte_order_select = 1'b1;
    w(HCS_ADDR_DATA_A, 8'hc3);
    w(HCS_ADDR_DATA_B, 8'hd4);
    rc(HCS_ADDR_STAT, 8'h10, "stat");
    core_rx_take = 1'b1;
    st(1);
    core_rx_take = 1'b0;
    st(2);
    chk("rxw", 24'h1d4c3,
        24'({core_receive_full, core_receive_word}));
    core_rx_take = 1'b1;
    st(1);
    {core_rx_take, byte_order_select} = 2'b00;
    transmit_request_enable = 1'b1;
    st(1);
    rc(HCS_ADDR_STAT, 8'h96, "stat");
    chk("req", 24'h1, 24'(host_request_pin));
    transmit_request_enable = 1'b0;
    k = 0;
    core_tx_valid = 1'b1;
    repeat (14) begin
      core_transmit_word = 16'h1000 + 16'(k);
      if (core_tx_ready === 1'b1) k++;
      st(1);
    end
    core_tx_valid = 1'b0;
    chk("fill", 24'd9, 24'(k));
    receive_request_enable = 1'b1;
    rc(HCS_ADDR_STAT, 8'h97, "stat");
    hcs_host_model_inst.ack_drv = 1'b1;
    st(5);
    chk("vec", 24'h15a, 24'({host_data_oe, host_data_out}));
    hcs_host_model_inst.ack_drv = 1'b0;
    split_request_mode = 1'b1;
    st(6);
    chk("pins", 24'h3,
        24'({host_request_pin, ack_pin_out, ack_pin_oe}));
    rc(HCS_ADDR_STAT, 8'h97, "stat");
    receive_request_enable = 1'b0;
    rc(HCS_ADDR_STAT, 8'h17, "stat");
    split_request_mode = 1'b0;
    for (int i = 0; i < 9; i++) begin
      byte_order_select = i[0];
      v = 8'(i);
      rc(HCS_ADDR_DATA_A, i[0] ? v : 8'h10, "rxa");
      rc(HCS_ADDR_DATA_B, i[0] ? 8'h10 : v, "rxb");
    end
    rc(HCS_ADDR_STAT, 8'h16, "stat");
    conclude();
  end
endmodule

bind hcs_top hcs_chk hcs_chk_inst (.clk, .nrst, .soft_rst, .indiv_rst,
  .stop_rst, .receive_request_enable, .transmit_request_enable,
  .split_request_mode, .host_request_pin, .ack_pin_out, .ack_pin_oe,
  .core_cmd_request, .core_cmd_vector_addr, .command_pending, .core_cmd_ack,
  .core_receive_full, .core_rx_take, .transfer_clear);
